// *** hdl/port_pkg.sv ***
// constants for the parallel port block
package port_pkg;

	localparam int         NPORT   = 9;
	// port slots in the internal arrays
	localparam int         IDX_P0  = 0;
	localparam int         IDX_P1  = 1;
	localparam int         IDX_P2  = 2;
	localparam int         IDX_P3  = 3;
	localparam int         IDX_P4  = 4;
	localparam int         IDX_P5  = 5;
	localparam int         IDX_P6  = 6;
	localparam int         IDX_P12 = 7;
	localparam int         IDX_P13 = 8;

	// output latch (port data) addresses
	localparam logic [15:0] ADDR_PORT [0:NPORT-1] = '{
		16'hFF00, 16'hFF01, 16'hFF02, 16'hFF03, 16'hFF04,
		16'hFF05, 16'hFF06, 16'hFF0C, 16'hFF0D};
	// direction register addresses, unused where no register exists
	localparam logic [15:0] ADDR_DIR [0:NPORT-1] = '{
		16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23, 16'h0000,
		16'hFF25, 16'hFF26, 16'hFF2C, 16'h0000};
	localparam logic        DIR_PRESENT [0:NPORT-1] = '{
		1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	localparam logic [15:0] ADDR_MODE4   = 16'hFF24;
	localparam logic [15:0] ADDR_KEYCTL  = 16'hFF27;
	localparam logic [15:0] ADDR_KEYFLAG = 16'hFF28;

	// implemented pins of each port
	localparam logic [7:0] PORT_MASK [0:NPORT-1] = '{
		8'h7F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h3F, 8'h07};
	// direction bits that always read 1 (no pin or input only)
	localparam logic [7:0] DIR_FIXED1 [0:NPORT-1] = '{
		8'h81, 8'hC0, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'hC0, 8'h00};
	localparam logic [7:0] DIR_RESET [0:NPORT-1] = '{
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h00};
	localparam logic [7:0] LATCH_RESET = 8'h00;

	localparam logic [7:0] MODE4_RESET  = 8'h10;
	localparam logic [2:0] MODE4_INPUT  = 3'b000;
	localparam logic [2:0] MODE4_OUTPUT = 3'b001;
	localparam logic [7:0] KEYCTL_RESET = 8'h02;
	localparam int         KEYCTL_WAKE_BIT = 0;
	localparam int         KEYFLAG_BIT     = 0;
	localparam logic [7:0] RDATA_IDLE   = 8'h00;

endpackage

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// *** hdl/key_edge_detect.sv ***
// falling edge detector on synchronised port 4 levels
`timescale 1ns/10ps
module key_edge_detect (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic [7:0] level_i,
	output logic      [7:0] fall_o
);
	logic [7:0] prev_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// resets low like the synchroniser, so release shows no edge
			prev_q <= 8'h00;
		end else begin
			prev_q <= level_i;
		end
	end

	assign fall_o = prev_q & ~level_i;
endmodule

// *** hdl/mcu_port_block.sv ***
// parallel port block: latches, direction, key return
`timescale 1ns/10ps
module mcu_port_block (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_B_I,
	// processor register access
	input  wire logic [15:0] ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        BIT_WR_I,
	input  wire logic [2:0]  BIT_SEL_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	// port 0
	input  wire logic [6:0]  P0_PIN_I,
	output logic      [6:0]  P0_OUT_O,
	output logic      [6:0]  P0_OE_O,
	output logic      [5:0]  EXT_IRQ_REQ_O,
	// port 1
	input  wire logic [5:0]  P1_PIN_I,
	output logic      [5:0]  P1_OUT_O,
	output logic      [5:0]  P1_OE_O,
	input  wire logic [5:0]  ADC_SEL_I,
	// port 2
	input  wire logic [7:0]  P2_PIN_I,
	output logic      [7:0]  P2_OUT_O,
	output logic      [7:0]  P2_OE_O,
	// port 3
	input  wire logic [7:0]  P3_PIN_I,
	output logic      [7:0]  P3_OUT_O,
	output logic      [7:0]  P3_OE_O,
	// port 4 and key return
	input  wire logic [7:0]  P4_PIN_I,
	output logic      [7:0]  P4_OUT_O,
	output logic      [7:0]  P4_OE_O,
	output logic             KEY_WAKE_O,
	// port 5
	input  wire logic [7:0]  P5_PIN_I,
	output logic      [7:0]  P5_OUT_O,
	output logic      [7:0]  P5_OE_O,
	// port 6
	input  wire logic [7:0]  P6_PIN_I,
	output logic      [7:0]  P6_OUT_O,
	output logic      [7:0]  P6_OE_O,
	// port 12
	input  wire logic [5:0]  P12_PIN_I,
	output logic      [5:0]  P12_OUT_O,
	output logic      [5:0]  P12_OE_O,
	// port 13 and pulse-width sharing
	input  wire logic [2:0]  PWM_SEL_I,
	input  wire logic [2:0]  PWM_I,
	output logic      [2:0]  P13_OUT_O,
	output logic      [2:0]  P13_OE_O
);

	localparam int N = port_pkg::NPORT;

	logic [7:0] pin_raw   [0:N-1];
	logic [7:0] pin_s     [0:N-1];
	logic [7:0] latch_q   [0:N-1];
	logic [7:0] dir_q     [0:N-1];
	logic [7:0] dir_d     [0:N-1];
	logic [7:0] drive_q   [0:N-1];
	logic [7:0] port_rd   [0:N-1];
	logic [7:0] mode4_q;
	logic [7:0] mode4_d;
	logic [7:0] keyctl_q;
	logic       keyflag_q;
	logic       keyflag_d;
	logic [7:0] keyflag_wr;
	logic [5:0] p0_toggle;
	logic [7:0] key_fall;
	logic [6:0] lat0_prev_q;
	logic [5:0] irq_q;
	logic       wake_q;
	logic [2:0] pin13_q;
	logic [7:0] rd_mux;
	logic [7:0] rdata_q;

	// whole-byte or single-bit write merge
	function automatic logic [7:0] merge_f(
		input logic [7:0] old,
		input logic [7:0] wd,
		input logic       bw,
		input logic [2:0] sel
	);
		logic [7:0] r;
		r = wd;
		if (bw) begin
			r      = old;
			r[sel] = wd[sel];
		end
		return r;
	endfunction

	// strobe and address come in as arguments so that continuous
	// assignments re-evaluate when either of them moves
	function automatic logic hit_f(
		input logic        we,
		input logic [15:0] ad,
		input logic [15:0] a
	);
		return we && (ad == a);
	endfunction

	// pin levels packed into byte slots
	assign pin_raw[port_pkg::IDX_P0]  = {1'b0, P0_PIN_I};
	assign pin_raw[port_pkg::IDX_P1]  = {2'b00, P1_PIN_I};
	assign pin_raw[port_pkg::IDX_P2]  = P2_PIN_I;
	assign pin_raw[port_pkg::IDX_P3]  = P3_PIN_I;
	assign pin_raw[port_pkg::IDX_P4]  = P4_PIN_I;
	assign pin_raw[port_pkg::IDX_P5]  = P5_PIN_I;
	assign pin_raw[port_pkg::IDX_P6]  = P6_PIN_I;
	assign pin_raw[port_pkg::IDX_P12] = {2'b00, P12_PIN_I};
	assign pin_raw[port_pkg::IDX_P13] = 8'h00;

	// port 4 mode register
	// stored as written, reset 10H
	assign mode4_d = hit_f(WR_I, ADDR_I, port_pkg::ADDR_MODE4)
		? merge_f(mode4_q, WDATA_I, BIT_WR_I, BIT_SEL_I) : mode4_q;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			mode4_q <= port_pkg::MODE4_RESET;
		end else begin
			mode4_q <= mode4_d;
		end
	end

	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_port
			pin_sync #(
				.W (8)
			) u_sync (
				.clk_i   (CLK_I),
				.rst_b_i (RST_B_I),
				.d_i     (pin_raw[k]),
				.q_o     (pin_s[k])
			);

			always_ff @(posedge CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					latch_q[k] <= port_pkg::LATCH_RESET;
				end else if (hit_f(WR_I, ADDR_I,
					port_pkg::ADDR_PORT[k])) begin
					latch_q[k] <= merge_f(latch_q[k], WDATA_I, BIT_WR_I,
						BIT_SEL_I) & port_pkg::PORT_MASK[k];
				end
			end

			if (k == port_pkg::IDX_P4) begin : g_mode4
				// one direction for all eight pins
				assign dir_d[k] = (mode4_d[2:0] == port_pkg::MODE4_OUTPUT)
					? 8'h00 : 8'hFF;
			end else if (k == port_pkg::IDX_P13) begin : g_outonly
				assign dir_d[k] = 8'h00;
			end else begin : g_dir
				// pin 0 of port 0 fixed input
				// byte or bit write, own address
				assign dir_d[k] = hit_f(WR_I, ADDR_I, port_pkg::ADDR_DIR[k])
					? (merge_f(dir_q[k], WDATA_I, BIT_WR_I, BIT_SEL_I)
						| port_pkg::DIR_FIXED1[k])
					: dir_q[k];
			end

			always_ff @(posedge CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					dir_q[k]   <= port_pkg::DIR_RESET[k];
					drive_q[k] <= ~port_pkg::DIR_RESET[k]
						& port_pkg::PORT_MASK[k];
				end else begin
					dir_q[k]   <= dir_d[k];
					drive_q[k] <= ~dir_d[k] & port_pkg::PORT_MASK[k];
				end
			end

			always_comb begin
				port_rd[k] = ((dir_q[k] & pin_s[k])
					| (~dir_q[k] & latch_q[k])) & port_pkg::PORT_MASK[k];
				if (k == port_pkg::IDX_P1) begin
					port_rd[k] = port_rd[k] & ~{2'b00, ADC_SEL_I};
				end
				if (k == port_pkg::IDX_P13) begin
					port_rd[k] = port_rd[k] & ~{5'b00000, PWM_SEL_I};
				end
			end
		end
	endgenerate

	// a latch bit that differs from its one-cycle-old copy just changed
	assign p0_toggle = latch_q[port_pkg::IDX_P0][6:1] ^ lat0_prev_q[6:1];

	// port 0 output change raises interrupt request
	// output-mode level change
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lat0_prev_q <= '0;
			irq_q       <= '0;
		end else begin
			lat0_prev_q <= latch_q[port_pkg::IDX_P0][6:0];
			irq_q       <= drive_q[port_pkg::IDX_P0][6:1] & p0_toggle;
		end
	end

	key_edge_detect u_key_edge (
		.clk_i   (CLK_I),
		.rst_b_i (RST_B_I),
		.level_i (pin_s[port_pkg::IDX_P4]),
		.fall_o  (key_fall)
	);

	// flag kept in bit 0 of the merged byte
	assign keyflag_wr = merge_f({7'h00, keyflag_q}, WDATA_I, BIT_WR_I,
		BIT_SEL_I);

	assign keyflag_d = hit_f(WR_I, ADDR_I, port_pkg::ADDR_KEYFLAG)
		? keyflag_wr[port_pkg::KEYFLAG_BIT] : keyflag_q;

	// key return control register
	// control resets 02H
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			keyctl_q <= port_pkg::KEYCTL_RESET;
		end else if (hit_f(WR_I, ADDR_I, port_pkg::ADDR_KEYCTL)) begin
			keyctl_q <= merge_f(keyctl_q, WDATA_I, BIT_WR_I, BIT_SEL_I);
		end
	end

	// key return flag and wake request
	// falling edge sets flag, set wins
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			keyflag_q <= 1'b0;
			wake_q    <= 1'b0;
		end else begin
			keyflag_q <= keyflag_d | (|key_fall);
			wake_q    <= keyflag_q & keyctl_q[port_pkg::KEYCTL_WAKE_BIT];
		end
	end

	// port 13 pin: pulse-width or latch
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pin13_q <= '0;
		end else begin
			pin13_q <= (PWM_SEL_I & PWM_I)
				| (~PWM_SEL_I & latch_q[port_pkg::IDX_P13][2:0]);
		end
	end

	// register read decode, unmapped reads zero
	always_comb begin
		rd_mux = port_pkg::RDATA_IDLE;
		for (int i = 0; i < N; i++) begin
			if (ADDR_I == port_pkg::ADDR_PORT[i]) begin
				rd_mux = port_rd[i];
			end
			if (port_pkg::DIR_PRESENT[i]
				&& ADDR_I == port_pkg::ADDR_DIR[i]) begin
				rd_mux = dir_q[i];
			end
		end
		if (ADDR_I == port_pkg::ADDR_MODE4) begin
			rd_mux = mode4_q;
		end
		if (ADDR_I == port_pkg::ADDR_KEYCTL) begin
			rd_mux = keyctl_q;
		end
		if (ADDR_I == port_pkg::ADDR_KEYFLAG) begin
			rd_mux = {7'h00, keyflag_q};
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rdata_q <= port_pkg::RDATA_IDLE;
		end else begin
			rdata_q <= RD_I ? rd_mux : port_pkg::RDATA_IDLE;
		end
	end

	// output assignments, all from flip-flops
	assign RDATA_O       = rdata_q;
	assign EXT_IRQ_REQ_O = irq_q;
	assign KEY_WAKE_O    = wake_q;
	assign P0_OUT_O      = latch_q[port_pkg::IDX_P0][6:0];
	assign P0_OE_O       = drive_q[port_pkg::IDX_P0][6:0];
	assign P1_OUT_O      = latch_q[port_pkg::IDX_P1][5:0];
	assign P1_OE_O       = drive_q[port_pkg::IDX_P1][5:0];
	assign P2_OUT_O      = latch_q[port_pkg::IDX_P2];
	assign P2_OE_O       = drive_q[port_pkg::IDX_P2];
	assign P3_OUT_O      = latch_q[port_pkg::IDX_P3];
	assign P3_OE_O       = drive_q[port_pkg::IDX_P3];
	assign P4_OUT_O      = latch_q[port_pkg::IDX_P4];
	assign P4_OE_O       = drive_q[port_pkg::IDX_P4];
	assign P5_OUT_O      = latch_q[port_pkg::IDX_P5];
	assign P5_OE_O       = drive_q[port_pkg::IDX_P5];
	assign P6_OUT_O      = latch_q[port_pkg::IDX_P6];
	assign P6_OE_O       = drive_q[port_pkg::IDX_P6];
	assign P12_OUT_O     = latch_q[port_pkg::IDX_P12][5:0];
	assign P12_OE_O      = drive_q[port_pkg::IDX_P12][5:0];
	assign P13_OUT_O     = pin13_q;
	assign P13_OE_O      = drive_q[port_pkg::IDX_P13][2:0];

endmodule

// *** testbench/port_monitor.sv ***
// assertion checker watching the parallel port block ports
`timescale 1ns/10ps
module port_monitor (
	input wire logic        CLK_I,
	input wire logic        RST_B_I,
	input wire logic [15:0] ADDR_I,
	input wire logic [7:0]  WDATA_I,
	input wire logic        WR_I,
	input wire logic        BIT_WR_I,
	input wire logic        RD_I,
	input wire logic [7:0]  RDATA_O,
	input wire logic [6:0]  P0_OUT_O,
	input wire logic [6:0]  P0_OE_O,
	input wire logic [5:0]  EXT_IRQ_REQ_O,
	input wire logic [7:0]  P2_OE_O,
	input wire logic [7:0]  P3_OUT_O,
	input wire logic [7:0]  P3_OE_O,
	input wire logic [7:0]  P4_OE_O,
	input wire logic        KEY_WAKE_O,
	input wire logic [2:0]  P13_OE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	logic byte_wr;
	logic key_wr;
	assign byte_wr = WR_I && !BIT_WR_I;
	assign key_wr = WR_I && (ADDR_I == 16'hFF27 || ADDR_I == 16'hFF28);
	sequence s_p0_change;
		byte_wr && ADDR_I == 16'hFF00
		&& (((WDATA_I[6:1] ^ P0_OUT_O[6:1]) & P0_OE_O[6:1]) != 6'h00);
	endsequence
	sequence s_p3_write;
		byte_wr && ADDR_I == 16'hFF03;
	endsequence
	a_p13_always_out: assert property (P13_OE_O == 3'b111)
		else $error("port 13 not driving");
	a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data without read");
	a_dir_drives_oe: assert property (byte_wr && ADDR_I == 16'hFF22
		|=> P2_OE_O == ~$past(WDATA_I)) else $error("direction not applied");
	a_latch_load: assert property (s_p3_write
		|=> P3_OUT_O == $past(WDATA_I)) else $error("latch not loaded");
	a_latch_holds: assert property (!(WR_I && ADDR_I == 16'hFF03)
		|=> $stable(P3_OUT_O)) else $error("latch changed unwritten");
	a_read_latch: assert property (RD_I && ADDR_I == 16'hFF03
		&& P3_OE_O == 8'hFF |=> RDATA_O == $past(P3_OUT_O))
		else $error("output mode read not latch");
	a_mode_out: assert property (byte_wr && ADDR_I == 16'hFF24
		&& WDATA_I[2:0] == 3'b001 |=> P4_OE_O == 8'hFF)
		else $error("port 4 not output");
	a_mode_in: assert property (byte_wr && ADDR_I == 16'hFF24
		&& WDATA_I[2:0] == 3'b000 |=> P4_OE_O == 8'h00)
		else $error("port 4 not input");
	a_irq_pulse: assert property (s_p0_change
		|-> ##2 EXT_IRQ_REQ_O != 6'h00) else $error("no interrupt request");
	a_wake_hold: assert property (KEY_WAKE_O && !key_wr && !$past(key_wr)
		|=> KEY_WAKE_O) else $error("key flag cleared by itself");
endmodule

// *** testbench/pin_partner.sv ***
// external pin model: a driven pin shows the latch, else the outside level
`timescale 1ns/10ps
module pin_partner #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] out_i,
	input  wire logic [W-1:0] ext_i,
	output logic      [W-1:0] pin_o
);
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// *** testbench/tb_mcu_port_block.sv ***
// self-checking bench for the parallel port block
`timescale 1ns/10ps
module tb_mcu_port_block;
	logic        clk = 0, rst_b = 0, wr = 0, bw = 0, rd = 0, wake;
	logic [15:0] addr = '0;
	logic [7:0]  wdata = '0, ext = 8'hFF, rdata, got;
	logic [2:0]  bs = '0, psel = '0, pwm = '0, p13_out, p13_oe;
	logic [5:0]  adc = '0, irq, p1_pin, p1_out, p1_oe;
	logic [6:0]  p0_pin, p0_out, p0_oe;
	logic [7:0]  p2_pin, p2_out, p2_oe, p3_pin, p3_out, p3_oe;
	logic [7:0]  p4_pin, p4_out, p4_oe;
	logic [7:0]  p5_out, p5_oe, p6_out, p6_oe;
	logic [5:0]  p12_out, p12_oe;
	int          n_errors = 0, tests_run = 0;
	logic [15:0] dadr [7] = '{16'hFF20, 16'hFF21, 16'hFF22, 16'hFF23,
		16'hFF25, 16'hFF26, 16'hFF2C};
	logic [7:0]  dfix [7] = '{8'h81, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hC0};
	mcu_port_block u_mcu_port_block (
		.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .BIT_WR_I(bw), .BIT_SEL_I(bs), .RD_I(rd), .RDATA_O(rdata),
		.P0_PIN_I(p0_pin), .P0_OUT_O(p0_out), .P0_OE_O(p0_oe),
		.EXT_IRQ_REQ_O(irq), .P1_PIN_I(p1_pin), .P1_OUT_O(p1_out),
		.P1_OE_O(p1_oe), .ADC_SEL_I(adc), .P2_PIN_I(p2_pin),
		.P2_OUT_O(p2_out), .P2_OE_O(p2_oe), .P3_PIN_I(p3_pin),
		.P3_OUT_O(p3_out), .P3_OE_O(p3_oe), .P4_PIN_I(p4_pin),
		.P4_OUT_O(p4_out), .P4_OE_O(p4_oe), .KEY_WAKE_O(wake),
		.P5_PIN_I(ext), .P5_OUT_O(p5_out), .P5_OE_O(p5_oe),
		.P6_PIN_I(ext), .P6_OUT_O(p6_out), .P6_OE_O(p6_oe),
		.P12_PIN_I(ext[5:0]), .P12_OUT_O(p12_out), .P12_OE_O(p12_oe),
		.PWM_SEL_I(psel), .PWM_I(pwm), .P13_OUT_O(p13_out),
		.P13_OE_O(p13_oe));
	pin_partner #(.W(7)) u_pin_partner_p0 (.oe_i(p0_oe), .out_i(p0_out),
		.ext_i(ext[6:0]), .pin_o(p0_pin));
	pin_partner #(.W(6)) u_pin_partner_p1 (.oe_i(p1_oe), .out_i(p1_out),
		.ext_i(ext[5:0]), .pin_o(p1_pin));
	pin_partner #(.W(8)) u_pin_partner_p2 (.oe_i(p2_oe), .out_i(p2_out),
		.ext_i(ext), .pin_o(p2_pin));
	pin_partner #(.W(8)) u_pin_partner_p3 (.oe_i(p3_oe), .out_i(p3_out),
		.ext_i(ext), .pin_o(p3_pin));
	pin_partner #(.W(8)) u_pin_partner_p4 (.oe_i(p4_oe), .out_i(p4_out),
		.ext_i(ext), .pin_o(p4_pin));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one access, strobes held until the taking edge
	task automatic acc(input logic [15:0] a, input logic [7:0] d,
		input logic w, b, r, input logic [2:0] s);
		addr = a;
		wdata = d;
		wr = w;
		bw = b;
		bs = s;
		rd = r;
		@(posedge clk);
		#2;
		got = rdata;
		wr = 0;
		bw = 0;
		rd = 0;
		@(posedge clk);
		#2;
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] d);
		acc(a, d, 1'b1, 1'b0, 1'b0, 3'd0);
	endtask
	task automatic rd8(input string nm, input logic [15:0] a,
		input logic [7:0] e);
		acc(a, 8'h00, 1'b0, 1'b0, 1'b1, 3'd0);
		chk(nm, got, e);
	endtask
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge clk);
		#2;
		rst_b = 1;
		for (int i = 0; i < 7; i++) rd8("dir reset", dadr[i], 8'hFF);
		rd8("mode4 reset", 16'hFF24, 8'h10);
		rd8("keyctl reset", 16'hFF27, 8'h02);
		rd8("unmapped", 16'hFF30, 8'h00);
		chk("p13 oe", {5'b0, p13_oe}, 8'h07);
		for (int i = 0; i < 7; i++) begin
			wr8(dadr[i], 8'h00);
			rd8("dir fixed", dadr[i], dfix[i]);
		end
		chk("p0 oe", {1'b0, p0_oe}, 8'h7E);
		chk("p1 oe", {2'b0, p1_oe}, 8'h3F);
		chk("p5 oe", p5_oe, 8'hFF);
		chk("p6 oe", p6_oe, 8'hFF);
		chk("p12 oe", {2'b0, p12_oe}, 8'h3F);
		wr8(16'hFF05, 8'hC3);
		chk("p5 out", p5_out, 8'hC3);
		wr8(16'hFF06, 8'h3C);
		chk("p6 out", p6_out, 8'h3C);
		wr8(16'hFF0C, 8'hFF);
		chk("p12 out", {2'b0, p12_out}, 8'h3F);
		wr8(16'hFF04, 8'h5A);
		chk("p4 out latch", p4_out, 8'h5A);
		chk("p4 oe kept", p4_oe, 8'h00);
		wr8(16'hFF23, 8'hFF);
		acc(16'hFF23, 8'h00, 1'b1, 1'b1, 1'b0, 3'd3);
		chk("p3 oe bit", p3_oe, 8'h08);
		rd8("dir bit", 16'hFF23, 8'hF7);
		rd8("dir indep", 16'hFF25, 8'h00);
		wr8(16'hFF23, 8'h00);
		wr8(16'hFF03, 8'hA5);
		chk("p3 out", p3_out, 8'hA5);
		rd8("p3 out read", 16'hFF03, 8'hA5);
		wr8(16'hFF23, 8'hFF);
		ext = 8'h3D;
		repeat (4) @(posedge clk);
		#2;
		chk("p3 latch kept", p3_out, 8'hA5);
		rd8("p3 pin read", 16'hFF03, 8'h3D);
		wr8(16'hFF03, 8'h11);
		chk("p3 latch in", p3_out, 8'h11);
		chk("p3 pin kept", p3_pin, 8'h3D);
		adc = 6'h01;
		wr8(16'hFF21, 8'hFF);
		// released pins need the synchroniser edges before a read
		repeat (2) @(posedge clk);
		#2;
		rd8("p1 analog", 16'hFF01, 8'h3C);
		psel = 3'b001;
		pwm = 3'b001;
		wr8(16'hFF0D, 8'h06);
		@(posedge clk);
		#2;
		chk("p13 out", {5'b0, p13_out}, 8'h07);
		rd8("p13 read", 16'hFF0D, 8'h06);
		wr8(16'hFF24, 8'h11);
		chk("p4 out", p4_oe, 8'hFF);
		wr8(16'hFF24, 8'h10);
		chk("p4 in", p4_oe, 8'h00);
		// serial pins 5 and 6 as inputs
		wr8(16'hFF22, 8'h60);
		chk("p2 oe", p2_oe, 8'h9F);
		repeat (2) @(posedge clk);
		#2;
		rd8("p2 mixed", 16'hFF02, 8'h20);
		wr8(16'hFF00, 8'h02);
		chk("irq", {2'b0, irq}, 8'h01);
		@(posedge clk);
		#2;
		chk("irq end", {2'b0, irq}, 8'h00);
		ext = 8'hFF;
		repeat (4) @(posedge clk);
		#2;
		wr8(16'hFF28, 8'h00);
		wr8(16'hFF27, 8'h03);
		ext = 8'h7F;
		repeat (6) @(posedge clk);
		#2;
		rd8("key flag", 16'hFF28, 8'h01);
		chk("wake", {7'b0, wake}, 8'h01);
		repeat (10) @(posedge clk);
		#2;
		chk("wake held", {7'b0, wake}, 8'h01);
		wr8(16'hFF28, 8'h00);
		chk("wake clear", {7'b0, wake}, 8'h00);
		conclude();
	end
endmodule
bind mcu_port_block port_monitor u_port_monitor (
	.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .BIT_WR_I(BIT_WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.P0_OUT_O(P0_OUT_O), .P0_OE_O(P0_OE_O), .EXT_IRQ_REQ_O(EXT_IRQ_REQ_O),
	.P2_OE_O(P2_OE_O), .P3_OUT_O(P3_OUT_O), .P3_OE_O(P3_OE_O),
	.P4_OE_O(P4_OE_O), .KEY_WAKE_O(KEY_WAKE_O), .P13_OE_O(P13_OE_O));
